// ### hdl/ddrb_pkg.sv
// ****************************************************************
// Shared constants of the burst-of-four SRAM port
// ****************************************************************
package ddrb_pkg;

   // Default organisation: 18-bit words, 1M words
   localparam int DDRB_DATA_W = 18;
   localparam int DDRB_ADDR_W = 20;
   // Each byte lane is nine bits wide, one mask bit per lane
   localparam int DDRB_LANE_W = 9;
   // Beats per burst and the low address bits that wrap
   localparam logic [2:0] DDRB_BEATS = 3'h4;
   localparam logic [1:0] DDRB_IDX_START = 2'h0;
   localparam logic [1:0] DDRB_IDX_STEP = 2'h1;
   // Synchroniser depth plus one: the strap is read after this many cycles
   localparam logic [1:0] DDRB_STRAP_WAIT = 2'h3;
   // Idle levels of the strobe and the data pin enable
   localparam logic DDRB_LOAD_IDLE = 1'b1;
   localparam logic DDRB_OE_OFF = 1'b0;

   // Active write burst
   typedef enum logic [0:0] {WR_IDLE, WR_BEATS} ddrb_wr_state_type;

endpackage

// ### hdl/ddrb_sync.sv
// ****************************************************************
// Two-flop synchroniser for pin levels
// ****************************************************************
module ddrb_sync #(
   parameter int WIDTH = 1,
   parameter logic RESET_VAL = 1'b0
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Pin levels and their synchronised copies
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;

   // First stage feeds only the second; nothing else may look at it
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         stage1_reg <= {WIDTH{RESET_VAL}};
         stage2_reg <= {WIDTH{RESET_VAL}};
      end else begin
         stage1_reg <= asyncIn;
         stage2_reg <= stage1_reg;
      end
   end

   assign syncOut = stage2_reg;

endmodule // ddrb_sync

// ### hdl/ddrb_two_buf.sv
// ****************************************************************
// Two-entry buffer with valid and ready on both sides
// ****************************************************************
module ddrb_two_buf #(
   parameter int WIDTH = 18
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Filling side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Draining side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);

   logic [WIDTH-1:0] slot [2];
   logic wrPtr_reg, wrPtr_next;
   logic rdPtr_reg, rdPtr_next;
   logic [1:0] count_reg, count_next;
   logic push, pop;

   // Honest flags: full blocks the filler, empty blocks the drainer
   assign inReady = (count_reg != 2'h2);
   assign outValid = (count_reg != 2'h0);
   assign outData = slot[rdPtr_reg];
   assign push = inValid & inReady;
   assign pop = outReady & outValid;

   // Pointer and occupancy update
   always_comb begin
      wrPtr_next = push ? ~wrPtr_reg : wrPtr_reg;
      rdPtr_next = pop ? ~rdPtr_reg : rdPtr_reg;
      count_next = count_reg;
      if (push && !pop) begin
         count_next = count_reg + 2'h1;
      end else if (pop && !push) begin
         count_next = count_reg - 2'h1;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wrPtr_reg <= 1'b0;
         rdPtr_reg <= 1'b0;
         count_reg <= 2'h0;
      end else begin
         wrPtr_reg <= wrPtr_next;
         rdPtr_reg <= rdPtr_next;
         count_reg <= count_next;
      end
   end

   // Storage carries no reset; occupancy says what is valid
   always_ff @(posedge core_clk) begin
      if (push) begin
         slot[wrPtr_reg] <= inData;
      end
   end

endmodule // ddrb_two_buf

// ### hdl/ddrb_sram_port.sv
// Overview of operation
// - Write: load with read_write_sel low; beats on both input clocks of t+1, t+2.
// - Read: load with read_write_sel high; beats at neg t+1, pos t+2, neg t+2, pos t+3.
// - Powers up deselected; a strobe sampled high is a no-op, pins undriven.
// - With the input clock stopped, strobe and write beats are ignored; dual-clock reads still launch on the output clocks.
// - First beat uses the loaded address; next three wrap the low two bits.
// - Write beats are captured on rising edges of both input clocks.
// - Read beats launch on output clock edges, or input clocks in single-clock mode.
// - 18-bit words: mask bit 0 gates bits 8:0, bit 1 gates 17:9.
// - 36-bit words: four mask bits gate the four nine-bit lanes.
// - The lane mask is sampled afresh with every data beat.
// - A load on the input clock rise right after an accepted load is ignored.
// - A read word fetched in the same core cycle as a write beat to it gets the new data, bypassing the array.
// - Both output clocks high at power-on select single-clock mode, fixed thereafter.
module ddrb_sram_port #(
   parameter int DATA_W = ddrb_pkg::DDRB_DATA_W,
   parameter int ADDR_W = ddrb_pkg::DDRB_ADDR_W,
   parameter int MASK_W = ddrb_pkg::DDRB_DATA_W / ddrb_pkg::DDRB_LANE_W
) (
   // Core clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Timing clocks from the controller, sampled as levels
   input wire logic input_timing_pos,
   input wire logic input_timing_neg,
   input wire logic output_timing_pos,
   input wire logic output_timing_neg,
   // Request pins
   input wire logic load_strobe_n,
   input wire logic read_write_sel,
   input wire logic [ADDR_W-1:0] address,
   input wire logic [MASK_W-1:0] byte_lane_mask_n,
   // Shared data pins, split into in, out and enable
   input wire logic [DATA_W-1:0] sharedDataIn,
   output logic [DATA_W-1:0] sharedDataOut,
   output logic sharedDataOe,
   // Strap state
   output logic singleClockMode
);
   import ddrb_pkg::*;

   // ****************************************************************
   // Parameter checks
   // ****************************************************************
   if (!((DATA_W == 18 && MASK_W == 2) || (DATA_W == 36 && MASK_W == 4))) begin : gBadOrg
      $error("ddrb_sram_port supports only 18-bit or 36-bit organisation");
   end
   if (ADDR_W < 2) begin : gBadAddr
      $error("ddrb_sram_port needs at least two address bits");
   end

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Burst order: low two bits advance modulo four, upper bits stay
   function automatic logic [ADDR_W-1:0] burstAddr(input logic [ADDR_W-1:0] base, input logic [1:0] idx);
      logic [1:0] low;
      low = base[1:0] + idx;
      return {base[ADDR_W-1:2], low};
   endfunction

   // Per-lane merge: a low mask bit takes the new lane, a high one keeps the old
   function automatic logic [DATA_W-1:0] laneMerge(input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] nw,
                                                   input logic [MASK_W-1:0] maskN);
      logic [DATA_W-1:0] res;
      res = old;
      for (int l = 0; l < MASK_W; l++) begin
         if (!maskN[l]) begin
            res[l*DDRB_LANE_W +: DDRB_LANE_W] = nw[l*DDRB_LANE_W +: DDRB_LANE_W];
         end
      end
      return res;
   endfunction

   // ****************************************************************
   // Pin synchronisers and edge detection
   // ****************************************************************
   localparam int SYNC_W = 5 + ADDR_W + MASK_W + DATA_W;

   logic ldSync;
   logic kSync, knSync, cSync, cnSync, rwSync;
   logic [ADDR_W-1:0] addrSync;
   logic [MASK_W-1:0] maskSync;
   logic [DATA_W-1:0] dataSync;
   logic kPrev_reg, knPrev_reg, cPrev_reg, cnPrev_reg;
   logic kPos, kNeg, cPos, cNeg, outPos, outNeg;

   // Strobe resets to its idle level so power-up is deselected
   ddrb_sync #(.WIDTH(1), .RESET_VAL(DDRB_LOAD_IDLE)) uLdSync (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .asyncIn(load_strobe_n),
      .syncOut(ldSync)
   );

   // Clocks, control, address, mask and data share one delay so they stay aligned
   ddrb_sync #(.WIDTH(SYNC_W), .RESET_VAL(1'b0)) uPinSync (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .asyncIn({input_timing_pos, input_timing_neg, output_timing_pos, output_timing_neg,
                read_write_sel, address, byte_lane_mask_n, sharedDataIn}),
      .syncOut({kSync, knSync, cSync, cnSync, rwSync, addrSync, maskSync, dataSync})
   );

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         kPrev_reg <= 1'b0;
         knPrev_reg <= 1'b0;
         cPrev_reg <= 1'b0;
         cnPrev_reg <= 1'b0;
      end else begin
         kPrev_reg <= kSync;
         knPrev_reg <= knSync;
         cPrev_reg <= cSync;
         cnPrev_reg <= cnSync;
      end
   end

   // Load, write and launch state move only on these edges; the read fetch runs on the core clock
   assign kPos = kSync & ~kPrev_reg;
   assign kNeg = knSync & ~knPrev_reg;
   assign cPos = cSync & ~cPrev_reg;
   assign cNeg = cnSync & ~cnPrev_reg;
   assign outPos = singleClockMode ? kPos : cPos;
   assign outNeg = singleClockMode ? kNeg : cNeg;

   // ****************************************************************
   // Single-clock strap
   // ****************************************************************
   logic [1:0] strapCnt_reg, strapCnt_next;
   logic singleClk_next;
   logic strapDone;

   assign strapDone = (strapCnt_reg == DDRB_STRAP_WAIT);

   // Sampled once after the synchroniser has filled, never again
   always_comb begin
      strapCnt_next = strapDone ? strapCnt_reg : strapCnt_reg + 2'h1;
      singleClk_next = singleClockMode;
      if (strapCnt_reg == DDRB_STRAP_WAIT - 2'h1) begin
         singleClk_next = cSync & cnSync;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         strapCnt_reg <= 2'h0;
         singleClockMode <= 1'b0;
      end else begin
         strapCnt_reg <= strapCnt_next;
         singleClockMode <= singleClk_next;
      end
   end

   // ****************************************************************
   // Load decode
   // ****************************************************************
   logic lastLoad_reg, lastLoad_next;
   logic loadOk, loadWr, loadRd;

   // High strobe is a no-op; a load straight after an accepted load is dropped
   assign loadOk = kPos & ~ldSync & strapDone & ~lastLoad_reg;
   assign loadWr = loadOk & ~rwSync;
   assign loadRd = loadOk & rwSync;

   always_comb begin
      lastLoad_next = kPos ? loadOk : lastLoad_reg;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         lastLoad_reg <= 1'b0;
      end else begin
         lastLoad_reg <= lastLoad_next;
      end
   end

   // ****************************************************************
   // Write path
   // ****************************************************************
   ddrb_wr_state_type wrState_reg, wrState_next;
   logic wrArmed_reg, wrArmed_next;
   logic [ADDR_W-1:0] wrLoadAddr_reg, wrLoadAddr_next;
   logic [ADDR_W-1:0] wrBase_reg, wrBase_next;
   logic [1:0] wrIdx_reg, wrIdx_next;
   logic [2:0] wrLeft_reg, wrLeft_next;
   logic wrFire;
   logic [ADDR_W-1:0] wrFireAddr;
   logic [DATA_W-1:0] memArray [2**ADDR_W];

   // A beat is taken on either input clock rise while a burst is open
   always_comb begin
      wrState_next = wrState_reg;
      wrArmed_next = wrArmed_reg;
      wrLoadAddr_next = wrLoadAddr_reg;
      wrBase_next = wrBase_reg;
      wrIdx_next = wrIdx_reg;
      wrLeft_next = wrLeft_reg;
      wrFire = 1'b0;
      wrFireAddr = burstAddr(wrBase_reg, wrIdx_reg);
      if (kPos && wrArmed_reg) begin
         // First beat at the rise after the load
         wrFire = 1'b1;
         wrFireAddr = wrLoadAddr_reg;
         wrBase_next = wrLoadAddr_reg;
         wrIdx_next = DDRB_IDX_STEP;
         wrLeft_next = DDRB_BEATS - 3'h1;
         wrState_next = WR_BEATS;
         wrArmed_next = 1'b0;
      end else if ((kPos || kNeg) && wrState_reg == WR_BEATS) begin
         wrFire = 1'b1;
         wrIdx_next = wrIdx_reg + DDRB_IDX_STEP;
         wrLeft_next = wrLeft_reg - 3'h1;
         wrState_next = (wrLeft_reg == 3'h1) ? WR_IDLE : WR_BEATS;
      end
      // A new load arms the next burst while the old one drains
      if (loadWr) begin
         wrArmed_next = 1'b1;
         wrLoadAddr_next = addrSync;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wrState_reg <= WR_IDLE;
         wrArmed_reg <= 1'b0;
         wrLoadAddr_reg <= '0;
         wrBase_reg <= '0;
         wrIdx_reg <= DDRB_IDX_START;
         wrLeft_reg <= 3'h0;
      end else begin
         wrState_reg <= wrState_next;
         wrArmed_reg <= wrArmed_next;
         wrLoadAddr_reg <= wrLoadAddr_next;
         wrBase_reg <= wrBase_next;
         wrIdx_reg <= wrIdx_next;
         wrLeft_reg <= wrLeft_next;
      end
   end

   // Mask taken with each beat; masked lanes keep their stored value
   always_ff @(posedge core_clk) begin
      if (wrFire) begin
         memArray[wrFireAddr] <= laneMerge(memArray[wrFireAddr], dataSync, maskSync);
      end
   end

   // ****************************************************************
   // Read fetch into the buffer
   // ****************************************************************
   logic rdPend_reg, rdPend_next;
   logic [ADDR_W-1:0] rdPendAddr_reg, rdPendAddr_next;
   logic [ADDR_W-1:0] fetchBase_reg, fetchBase_next;
   logic [1:0] fetchIdx_reg, fetchIdx_next;
   logic [2:0] fetchLeft_reg, fetchLeft_next;
   logic [ADDR_W-1:0] fetchAddr;
   logic [DATA_W-1:0] fetchWord;
   logic bufInReady, bufOutValid, bufPop;
   logic [DATA_W-1:0] bufOutData;

   // Words are fetched just in time: the full buffer holds the fetcher back,
   // so a word is read only after the beat two ahead has gone out
   assign fetchAddr = burstAddr(fetchBase_reg, fetchIdx_reg);
   always_comb begin
      fetchWord = memArray[fetchAddr];
      if (wrFire && wrFireAddr == fetchAddr) begin
         fetchWord = laneMerge(fetchWord, dataSync, maskSync);
      end
   end

   always_comb begin
      rdPend_next = rdPend_reg;
      rdPendAddr_next = rdPendAddr_reg;
      fetchBase_next = fetchBase_reg;
      fetchIdx_next = fetchIdx_reg;
      fetchLeft_next = fetchLeft_reg;
      if (fetchLeft_reg == 3'h0 && rdPend_reg) begin
         fetchBase_next = rdPendAddr_reg;
         fetchIdx_next = DDRB_IDX_START;
         fetchLeft_next = DDRB_BEATS;
         rdPend_next = 1'b0;
      end else if (fetchLeft_reg != 3'h0 && bufInReady) begin
         fetchIdx_next = fetchIdx_reg + DDRB_IDX_STEP;
         fetchLeft_next = fetchLeft_reg - 3'h1;
      end
      // A new load wins over the hand-off in the same cycle
      if (loadRd) begin
         rdPend_next = 1'b1;
         rdPendAddr_next = addrSync;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdPend_reg <= 1'b0;
         rdPendAddr_reg <= '0;
         fetchBase_reg <= '0;
         fetchIdx_reg <= DDRB_IDX_START;
         fetchLeft_reg <= 3'h0;
      end else begin
         rdPend_reg <= rdPend_next;
         rdPendAddr_reg <= rdPendAddr_next;
         fetchBase_reg <= fetchBase_next;
         fetchIdx_reg <= fetchIdx_next;
         fetchLeft_reg <= fetchLeft_next;
      end
   end

   ddrb_two_buf #(.WIDTH(DATA_W)) uReadBuf (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .inValid(fetchLeft_reg != 3'h0),
      .inReady(bufInReady),
      .inData(fetchWord),
      .outValid(bufOutValid),
      .outReady(bufPop),
      .outData(bufOutData)
   );

   // ****************************************************************
   // Read launch onto the pins
   // ****************************************************************
   logic armPos_reg, armPos_next;
   logic armNeg_reg, armNeg_next;
   logic [2:0] launchLeft_reg, launchLeft_next;
   logic [2:0] leftEff;
   logic [DATA_W-1:0] dataOut_next;
   logic oe_next;

   // Latency: wait for the output pos rise after the load, then launch
   // four beats starting at the following output neg rise
   always_comb begin
      armPos_next = armPos_reg;
      armNeg_next = armNeg_reg;
      if (outPos && armPos_reg) begin
         armPos_next = 1'b0;
         armNeg_next = 1'b1;
      end else if (outNeg && armNeg_reg) begin
         armNeg_next = 1'b0;
      end
      // The load edge itself may coincide with the output pos rise; the load wins
      if (loadRd) begin
         armPos_next = 1'b1;
      end
   end

   assign leftEff = (outNeg && armNeg_reg) ? DDRB_BEATS : launchLeft_reg;
   assign bufPop = (outPos || outNeg) && leftEff != 3'h0 && bufOutValid;

   // Each output rise either launches a beat or releases the pins
   always_comb begin
      launchLeft_next = launchLeft_reg;
      dataOut_next = sharedDataOut;
      oe_next = sharedDataOe;
      if (outPos || outNeg) begin
         if (leftEff != 3'h0) begin
            launchLeft_next = leftEff - 3'h1;
            dataOut_next = bufOutData;
            oe_next = 1'b1;
         end else begin
            oe_next = DDRB_OE_OFF;
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         armPos_reg <= 1'b0;
         armNeg_reg <= 1'b0;
         launchLeft_reg <= 3'h0;
         sharedDataOut <= '0;
         sharedDataOe <= DDRB_OE_OFF;
      end else begin
         armPos_reg <= armPos_next;
         armNeg_reg <= armNeg_next;
         launchLeft_reg <= launchLeft_next;
         sharedDataOut <= dataOut_next;
         sharedDataOe <= oe_next;
      end
   end

endmodule // ddrb_sram_port

// ### testbench/ddrb_sram_port_props.sv
// ************************************************************
// Burst port checks
// ************************************************************
module ddrb_sram_port_props #(
   parameter int DATA_W = 18
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Pins from the controller
   input wire logic input_timing_pos,
   input wire logic input_timing_neg,
   input wire logic output_timing_pos,
   input wire logic output_timing_neg,
   input wire logic load_strobe_n,
   input wire logic read_write_sel,
   // Device outputs
   input wire logic [DATA_W-1:0] sharedDataOut,
   input wire logic sharedDataOe,
   input wire logic singleClockMode
);
   timeunit 1ns;
   timeprecision 1ps;
   logic refPos, refNeg, refEdge, posPrev_reg, negPrev_reg, kPrev_reg;
   logic [3:0] rdCnt_reg, edgeAge_reg, relCnt_reg;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);
   // Single-clock mode: input pair times reads
   assign refPos = singleClockMode ? input_timing_pos : output_timing_pos;
   assign refNeg = singleClockMode ? input_timing_neg : output_timing_neg;
   assign refEdge = (refPos && !posPrev_reg) || (refNeg && !negPrev_reg);
   // Output edges since a read load; saturates when idle
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         posPrev_reg <= 1'b0;
         negPrev_reg <= 1'b0;
         kPrev_reg <= 1'b0;
         rdCnt_reg <= 4'hF;
         edgeAge_reg <= 4'hF;
         relCnt_reg <= 4'h0;
      end else begin
         posPrev_reg <= refPos;
         negPrev_reg <= refNeg;
         kPrev_reg <= input_timing_pos;
         if (relCnt_reg != 4'hF) begin
            relCnt_reg <= relCnt_reg + 4'h1;
         end
         if (refEdge) begin
            edgeAge_reg <= 4'h0;
         end else if (edgeAge_reg != 4'hF) begin
            edgeAge_reg <= edgeAge_reg + 4'h1;
         end
         if (input_timing_pos && !kPrev_reg && !load_strobe_n && read_write_sel) begin
            rdCnt_reg <= 4'h0;
         end else if (refEdge && rdCnt_reg != 4'hF) begin
            rdCnt_reg <= rdCnt_reg + 4'h1;
         end
      end
   end
   chk_oe_starts: assert property ($changed(rdCnt_reg) && rdCnt_reg == 4'h3 |-> ##[1:5] sharedDataOe)
      else $error("no drive at read");
   chk_oe_holds: assert property (rdCnt_reg inside {4'h4, 4'h5, 4'h6} |-> sharedDataOe)
      else $error("drive dropped");
   chk_oe_stops: assert property ($changed(rdCnt_reg) && rdCnt_reg == 4'h7 |-> ##[1:5] !sharedDataOe)
      else $error("drive kept");
   chk_oe_window: assert property (sharedDataOe |-> rdCnt_reg >= 4'h3 && rdCnt_reg <= 4'h7)
      else $error("drive outside read");
   chk_oe_edge: assert property ($changed(sharedDataOe) |-> rdCnt_reg == 4'h3 || rdCnt_reg == 4'h7)
      else $error("drive off edge");
   chk_out_edge: assert property ($changed(sharedDataOut) |-> edgeAge_reg <= 4'h5 && rdCnt_reg inside {[4'h3:4'h7]})
      else $error("data off edge");
   chk_strap_value: assert property (relCnt_reg == 4'h6 |-> singleClockMode == (output_timing_pos && output_timing_neg))
      else $error("strap wrong");
   chk_strap_fixed: assert property (relCnt_reg > 4'h6 |-> $stable(singleClockMode))
      else $error("strap moved");
   // Scenarios
   cover property ($rose(sharedDataOe));
   cover property (input_timing_pos && !kPrev_reg && !load_strobe_n && !read_write_sel);
   cover property (singleClockMode && sharedDataOe);
endmodule // ddrb_sram_port_props

bind ddrb_sram_port ddrb_sram_port_props #(.DATA_W(DATA_W)) chk (.core_clk(core_clk), .arst_n(arst_n),
   .input_timing_pos(input_timing_pos), .input_timing_neg(input_timing_neg),
   .output_timing_pos(output_timing_pos), .output_timing_neg(output_timing_neg),
   .load_strobe_n(load_strobe_n), .read_write_sel(read_write_sel), .sharedDataOut(sharedDataOut),
   .sharedDataOe(sharedDataOe), .singleClockMode(singleClockMode));

// ### testbench/ddrb_ctrl_model.sv
// ************************************************************
// Controller model
// ************************************************************
module ddrb_ctrl_model (
   // Core clock
   input wire logic core_clk,
   // Pins towards the port
   output logic kPos,
   output logic kNeg,
   output logic cPos,
   output logic cNeg,
   output logic loadN,
   output logic rdSel,
   output logic [ddrb_pkg::DDRB_ADDR_W-1:0] addr,
   output logic [1:0] maskN,
   output logic [ddrb_pkg::DDRB_DATA_W-1:0] pinData,
   // Device side of the shared pins
   input wire logic [ddrb_pkg::DDRB_DATA_W-1:0] devOut,
   input wire logic devOe
);
   timeunit 1ns;
   timeprecision 1ps;
   import ddrb_pkg::*;
   localparam int HALF = 6;
   logic single;
   logic [DDRB_DATA_W-1:0] drv;
   // Device wins the wire; released pins toggle
   assign pinData = devOe ? devOut : drv;
   // Power-up: dual-clock strap, deselected
   initial begin
      single = 1'b0;
      kPos = 1'b0;
      kNeg = 1'b1;
      cPos = 1'b0;
      cNeg = 1'b1;
      loadN = 1'b1;
      rdSel = 1'b0;
      addr = '0;
      maskN = 2'h3;
      drv = '0;
   end
   // Half pin-clock period; n above HALF parks clocks
   task automatic half(input logic k, input int n, input logic wr, input logic [DDRB_DATA_W-1:0] d,
                       input logic [1:0] m);
      @(negedge core_clk);
      kPos <= k;
      kNeg <= ~k;
      cPos <= single | k;
      cNeg <= single | ~k;
      drv <= wr ? d : ~drv;
      maskN <= m;
      repeat (n - 1) @(negedge core_clk);
   endtask
   // One burst; read beats taken before the next output rise
   task automatic burst(input logic rd, input logic [DDRB_ADDR_W-1:0] a, input logic [3:0][DDRB_DATA_W-1:0] d,
                        input logic [3:0][1:0] m, input int stop, output logic [3:0][DDRB_DATA_W-1:0] q,
                        output logic [3:0] oe);
      loadN <= 1'b0;
      rdSel <= rd;
      addr <= a;
      half(1'b1, HALF, 1'b0, '0, 2'h3);
      // Load held into next rise as a write: ignored
      rdSel <= 1'b0;
      addr <= ~a;
      half(1'b0, HALF, 1'b0, '0, 2'h3);
      half(1'b1, HALF, !rd, d[0], m[0]);
      loadN <= 1'b1;
      half(1'b0, HALF, !rd, d[1], m[1]);
      q[0] = devOut;
      oe[0] = devOe;
      half(1'b1, HALF + stop, !rd, d[2], m[2]);
      q[1] = devOut;
      oe[1] = devOe;
      half(1'b0, HALF, !rd, d[3], m[3]);
      q[2] = devOut;
      oe[2] = devOe;
      // No load at t+3: read-to-write idle
      half(1'b1, HALF, 1'b0, '0, 2'h3);
      q[3] = devOut;
      oe[3] = devOe;
      half(1'b0, HALF, 1'b0, '0, 2'h3);
   endtask
endmodule // ddrb_ctrl_model

// ### testbench/ddrb_sram_port_tb.sv
// ************************************************************
// Bench of the burst port
// ************************************************************
module ddrb_sram_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ddrb_pkg::*;
   logic core_clk;
   logic arst_n;
   logic kPos, kNeg, cPos, cNeg, loadN, rdSel;
   logic [DDRB_ADDR_W-1:0] addr;
   logic [1:0] maskN;
   logic [DDRB_DATA_W-1:0] pinData;
   logic [DDRB_DATA_W-1:0] sharedDataOut;
   logic sharedDataOe, singleClockMode;
   logic [DDRB_DATA_W-1:0] mem [int];
   int mismatches, nChecks;
   ddrb_ctrl_model ctl (.core_clk(core_clk), .kPos(kPos), .kNeg(kNeg), .cPos(cPos), .cNeg(cNeg),
      .loadN(loadN), .rdSel(rdSel), .addr(addr), .maskN(maskN), .pinData(pinData),
      .devOut(sharedDataOut), .devOe(sharedDataOe));
   ddrb_sram_port dut (.core_clk(core_clk), .arst_n(arst_n), .input_timing_pos(kPos), .input_timing_neg(kNeg),
      .output_timing_pos(cPos), .output_timing_neg(cNeg), .load_strobe_n(loadN), .read_write_sel(rdSel),
      .address(addr), .byte_lane_mask_n(maskN), .sharedDataIn(pinData), .sharedDataOut(sharedDataOut),
      .sharedDataOe(sharedDataOe), .singleClockMode(singleClockMode));
   // 200 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   task automatic endOfTest;
      $display("checks %0d mismatches %0d", nChecks, mismatches);
      if (mismatches == 0 && nChecks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic cmp(input logic [DDRB_DATA_W-1:0] got, input logic [DDRB_DATA_W-1:0] exp);
      nChecks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmpFlag(input logic got, input logic exp);
      nChecks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask
   // One burst, mirrored in the word model
   task automatic run(input logic rd, input logic [DDRB_ADDR_W-1:0] a, input logic [3:0][1:0] m, input int stop);
      logic [3:0][DDRB_DATA_W-1:0] d;
      logic [3:0][DDRB_DATA_W-1:0] q;
      logic [3:0] oe;
      logic [DDRB_ADDR_W-1:0] b;
      for (int i = 0; i < 4; i++) begin
         d[i] = DDRB_DATA_W'($urandom);
      end
      ctl.burst(rd, a, d, m, stop, q, oe);
      for (int i = 0; i < 4; i++) begin
         b = {a[DDRB_ADDR_W-1:2], a[1:0] + 2'(i)};
         if (rd) begin
            cmp(q[i], mem[b]);
            cmpFlag(oe[i], 1'b1);
         end else begin
            for (int l = 0; l < 2; l++) begin
               if (!m[i][l]) begin
                  mem[b][l * 9 +: 9] = d[i][l * 9 +: 9];
               end
            end
         end
      end
   endtask
   // Dual-clock bursts, then reset into single-clock mode
   initial begin
      logic [DDRB_ADDR_W-1:0] a;
      logic [DDRB_ADDR_W-1:0] keep;
      mismatches = 0;
      nChecks = 0;
      arst_n = 1'b0;
      void'($urandom(32'h5233));
      repeat (8) @(negedge core_clk);
      arst_n = 1'b1;
      repeat (10) @(negedge core_clk);
      cmpFlag(singleClockMode, 1'b0);
      for (int i = 0; i < 3; i++) begin
         ctl.rdSel <= 1'($urandom);
         ctl.half(1'b1, 6, 1'b0, '0, 2'h3);
         ctl.half(1'b0, 6, 1'b0, '0, 2'h3);
         cmpFlag(sharedDataOe, 1'b0);
      end
      for (int s = 0; s < 4; s++) begin
         a = DDRB_ADDR_W'($urandom);
         a[1:0] = 2'(s);
         if (s == 0) begin
            keep = a;
         end
         run(1'b0, a, '0, 0);
         run(1'b0, a, {2'(s), 2'(s + 1), 2'(s + 2), 2'(s + 3)}, 0);
         run(1'b1, a, '1, s * 10);
      end
      run(1'b1, keep, '1, 0);
      // Output clocks high across reset: single-clock strap
      ctl.single = 1'b1;
      ctl.cPos <= 1'b1;
      ctl.cNeg <= 1'b1;
      arst_n = 1'b0;
      repeat (8) @(negedge core_clk);
      arst_n = 1'b1;
      repeat (10) @(negedge core_clk);
      cmpFlag(singleClockMode, 1'b1);
      a = DDRB_ADDR_W'($urandom);
      run(1'b0, a, '0, 0);
      run(1'b1, a, '1, 0);
      endOfTest();
   end
   // Hang guard
   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      endOfTest();
   end
endmodule // ddrb_sram_port_tb
